//--- isr_delay.sv
// counts a fixed number of cycles after a start pulse
`timescale 1ns/1ps
module isr_delay #(
   parameter int CYC = 4
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   output logic o_done
);
   // one stage a cycle: starts closer than CYC apart all come out
   // instead of a restart swallowing the earlier one; CYC of 2 or more
   logic [CYC-1:0] line_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         line_reg <= '0;
      end else begin
         line_reg <= {line_reg[CYC-2:0], i_start};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= line_reg[CYC-1];
      end
   end
endmodule

//--- isr_gate.sv
// rate gate: passes a request only after a minimum spacing of cycles
`timescale 1ns/1ps
module isr_gate #(
   parameter int SPACE = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   output logic o_take
);
   logic [isr_pkg::SPACE_W-1:0] cnt_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_take <= 1'b0;
      end else begin
         o_take <= i_req && (cnt_reg == '0);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= '0;
      end else if (i_req && (cnt_reg == '0)) begin
         cnt_reg <= isr_pkg::SPACE_W'(SPACE - 1);
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   AST_GATE_SPACE: assert property (@(posedge i_clk) disable iff (i_rst)
      o_take |=> !o_take) else $error("gate passed back to back");
endmodule

//--- isr_partner.sv
// behavioural request source and pll lock model facing the block
`timescale 1ns/1ps
module isr_partner #(
   parameter int LOCK_CYC = 15
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [isr_pkg::NUM_EXT-1:0] i_arm,
   input wire logic i_level,
   input wire logic i_fetch,
   input wire logic i_exec,
   input wire logic i_pll_enable,
   output logic [isr_pkg::NUM_EXT-1:0] o_ext_req,
   output logic o_pll_locked
);
   logic [isr_pkg::NUM_EXT-1:0] held_reg;
   logic [isr_pkg::NUM_EXT-1:0] drop;
   int lock_cnt;
   // line 0 lets go one cycle after fetch, the others one cycle after exec, well inside the limits
   assign drop = i_exec ? '1 : isr_pkg::NUM_EXT'(i_fetch);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         held_reg <= '0;
      end else begin
         held_reg <= (held_reg | (i_arm & {isr_pkg::NUM_EXT{i_level}})) &
            ~drop;
      end
   end
   assign o_ext_req = i_arm | held_reg;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lock_cnt <= 0;
         o_pll_locked <= 1'b1;
      end else if (!i_pll_enable) begin
         lock_cnt <= LOCK_CYC;
         o_pll_locked <= 1'b0;
      end else if (lock_cnt != 0) begin
         lock_cnt <= lock_cnt - 1;
         o_pll_locked <= (lock_cnt == 1);
      end
   end
endmodule

//--- isr_pkg.sv
// shared constants and carrier types for interrupt and stop-recovery timing
package isr_pkg;
   // core clock
   localparam int CLK_PERIOD_PS = 5000;
   // request-to-service least delays, in hundredths of a core cycle
   localparam int FETCH_DLY_C100 = 425;
   localparam int EXEC_DLY_C100 = 725;
   localparam int GPO_DLY_C100 = 890;
   localparam int DMA_DLY_C100 = 425;
   // least times round up to whole cycles
   localparam int FETCH_CYC = (FETCH_DLY_C100 + 99) / 100;
   localparam int EXEC_CYC = (EXEC_DLY_C100 + 99) / 100;
   localparam int GPO_CYC = (GPO_DLY_C100 + 99) / 100;
   localparam int DMA_CYC = (DMA_DLY_C100 + 99) / 100;
   // stop exit: STOP_DLY_CYC, NODLY_CYC and PLLRUN_CYC in cycles, the others in hundredths of a cycle
   localparam int STOP_DLY_CYC = 131072;
   localparam int NODLY_C100 = 2375;
   localparam int PLLRUN_C100 = 1000;
   localparam int NODLY_CYC = (NODLY_C100 + 99) / 100;
   localparam int PLLRUN_CYC = PLLRUN_C100 / 100;
   // acceptance spacing in core cycles; SPACE_W and CNT_W are widths, NUM_EXT the external line count
   localparam int PER_SPACE = 12;
   localparam int DMAC_SPACE = 8;
   localparam int EDGE_SPACE = 8;
   localparam int LEVEL_SPACE = 12;
   localparam int DRD_SPACE = 6;
   localparam int DWR_SPACE = 7;
   localparam int DTMR_SPACE = 2;
   localparam int DEXT_SPACE = 3;
   localparam int SPACE_W = 4;
   localparam int NUM_EXT = 5;
   localparam int CNT_W = 18;
   // apb map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0C;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   // ctrl bits
   localparam int CTRL_PLL_RUN = 0;
   localparam int CTRL_NO_DLY = 1;
   localparam int CTRL_LEVEL = 2;
   localparam int CTRL_STOP = 3;
   localparam int CTRL_PLL_EN = 4;
   // status bits
   localparam int ST_FETCH = 0;
   localparam int ST_EXEC = 1;
   localparam int ST_WAKE = 2;
   localparam int ST_DMA = 3;
   localparam int ST_W = 4;

   typedef enum logic [2:0] {
      ISR_IDLE = 3'b000,
      ISR_WAIT_FETCH = 3'b001,
      ISR_WAIT_EXEC = 3'b010,
      ISR_WAIT_GPO = 3'b011,
      ISR_STOPPED = 3'b100,
      ISR_LOCK = 3'b101,
      ISR_RECOVER = 3'b110
   } isr_state_type;

   typedef struct packed {
      logic fetch;
      logic exec;
      logic gpo;
      logic dma;
   } isr_strobe_type;
endpackage

//--- isr_top.sv
// interrupt latency, request rate limiting and stop-exit sequencing
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module isr_top #(
   parameter int STOP_DLY = isr_pkg::STOP_DLY_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [isr_pkg::NUM_EXT-1:0] i_ext_req,
   input wire logic i_periph_req,
   input wire logic i_dmac_req,
   input wire logic i_dma_rd_trig,
   input wire logic i_dma_wr_trig,
   input wire logic i_dma_tmr_trig,
   input wire logic i_dma_ext_trig,
   input wire logic i_pll_locked,
   input wire logic i_gpo_req,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_fetch,
   output logic o_exec,
   output logic o_gpo_valid,
   output logic o_dma_access,
   output logic o_periph_take,
   output logic o_dmac_take,
   output logic [3:0] o_dma_take,
   output logic o_pll_enable,
   output logic o_irq
);
   isr_pkg::isr_state_type state_reg;
   isr_pkg::isr_strobe_type strb_reg;
   logic [31:0] ctrl_reg;
   logic [isr_pkg::ST_W-1:0] stat_reg;
   logic [isr_pkg::ST_W-1:0] mask_reg;
   logic [isr_pkg::CNT_W-1:0] cnt_reg;
   logic [isr_pkg::SPACE_W-1:0] lat_reg;
   logic ext_any;
   logic ext_edge_take;
   logic ext_lvl_take;
   logic ext_take;
   logic [isr_pkg::NUM_EXT-1:0] ext_prev_reg;
   logic ext_rise;
   logic dma_start;
   logic dma_done;
   logic apb_acc;
   logic rd_stat;
   logic [isr_pkg::ST_W-1:0] ev;
   logic [isr_pkg::ST_W-1:0] stat_next;

   assign ext_any = |i_ext_req;
   assign ext_rise = |(i_ext_req & ~ext_prev_reg);
   assign apb_acc = i_psel && i_penable && o_pready;
   assign rd_stat = apb_acc && !i_pwrite && (i_paddr == isr_pkg::ADDR_STAT);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_prev_reg <= '0;
      end else begin
         ext_prev_reg <= i_ext_req;
      end
   end

   // edge and level paths get separate spacing
   isr_gate #(.SPACE(isr_pkg::EDGE_SPACE)) u_ext_edge (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_req(ext_rise && !ctrl_reg[isr_pkg::CTRL_LEVEL]),
      .o_take(ext_edge_take));
   isr_gate #(.SPACE(isr_pkg::LEVEL_SPACE)) u_ext_lvl (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_req(ext_any && ctrl_reg[isr_pkg::CTRL_LEVEL]),
      .o_take(ext_lvl_take));
   assign ext_take = ext_edge_take || ext_lvl_take;

   isr_gate #(.SPACE(isr_pkg::PER_SPACE)) u_per (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_periph_req),
      .o_take(o_periph_take));
   isr_gate #(.SPACE(isr_pkg::DMAC_SPACE)) u_dmac (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_dmac_req),
      .o_take(o_dmac_take));
   isr_gate #(.SPACE(isr_pkg::DRD_SPACE)) u_drd (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_dma_rd_trig),
      .o_take(o_dma_take[0]));
   isr_gate #(.SPACE(isr_pkg::DWR_SPACE)) u_dwr (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_dma_wr_trig),
      .o_take(o_dma_take[1]));
   isr_gate #(.SPACE(isr_pkg::DTMR_SPACE)) u_dtmr (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_dma_tmr_trig),
      .o_take(o_dma_take[2]));
   isr_gate #(.SPACE(isr_pkg::DEXT_SPACE)) u_dext (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(i_dma_ext_trig),
      .o_take(o_dma_take[3]));

   // dma address counted from the raw trigger, gate adds one cycle
   assign dma_start = o_dma_take[3];
   isr_delay #(.CYC(isr_pkg::DMA_CYC - 1)) u_dmadly (
      .i_clk(i_clk), .i_rst(i_rst), .i_start(dma_start),
      .o_done(dma_done));

   // interrupt and stop-exit sequencer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= isr_pkg::ISR_IDLE;
         lat_reg <= '0;
         cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            isr_pkg::ISR_IDLE: begin
               lat_reg <= 4'h1;
               if (ctrl_reg[isr_pkg::CTRL_STOP]) begin
                  state_reg <= isr_pkg::ISR_STOPPED;
               end else if (ext_take) begin
                  state_reg <= isr_pkg::ISR_WAIT_FETCH;
               end
            end
            isr_pkg::ISR_WAIT_FETCH: begin
               lat_reg <= lat_reg + 1'b1;
               if (lat_reg == 4'(isr_pkg::FETCH_CYC - 1)) begin
                  state_reg <= isr_pkg::ISR_WAIT_EXEC;
               end
            end
            isr_pkg::ISR_WAIT_EXEC: begin
               lat_reg <= lat_reg + 1'b1;
               if (lat_reg == 4'(isr_pkg::EXEC_CYC - 1)) begin
                  state_reg <= isr_pkg::ISR_WAIT_GPO;
               end
            end
            isr_pkg::ISR_WAIT_GPO: begin
               lat_reg <= lat_reg + 1'b1;
               if (lat_reg == 4'(isr_pkg::GPO_CYC - 1)) begin
                  state_reg <= isr_pkg::ISR_IDLE;
               end
            end
            isr_pkg::ISR_STOPPED: begin
               cnt_reg <= '0;
               if (ext_prev_reg[0]) begin
                  // lock term is zero when the pll stays up
                  if (ctrl_reg[isr_pkg::CTRL_PLL_RUN] ||
                      !ctrl_reg[isr_pkg::CTRL_PLL_EN]) begin
                     state_reg <= isr_pkg::ISR_RECOVER;
                  end else begin
                     state_reg <= isr_pkg::ISR_LOCK;
                  end
               end
            end
            isr_pkg::ISR_LOCK: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (i_pll_locked) begin
                  state_reg <= isr_pkg::ISR_RECOVER;
                  cnt_reg <= '0;
               end
            end
            isr_pkg::ISR_RECOVER: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CNT_W_TARGET()) begin
                  state_reg <= isr_pkg::ISR_IDLE;
               end
            end
            default: begin
               state_reg <= isr_pkg::ISR_IDLE;
            end
         endcase
      end
   end

   function automatic logic [isr_pkg::CNT_W-1:0] CNT_W_TARGET();
      logic [isr_pkg::CNT_W-1:0] t;
      t = isr_pkg::CNT_W'(isr_pkg::PLLRUN_CYC - 2);
      if (!ctrl_reg[isr_pkg::CTRL_PLL_RUN]) begin
         if (ctrl_reg[isr_pkg::CTRL_NO_DLY]) begin
            t = isr_pkg::CNT_W'(isr_pkg::NODLY_CYC - 2);
         end else begin
            t = isr_pkg::CNT_W'(STOP_DLY - 2);
         end
      end
      return t;
   endfunction

   // strobes from the sequencer and the dma delay, one cycle each
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strb_reg <= '0;
      end else begin
         strb_reg.fetch <= (state_reg == isr_pkg::ISR_WAIT_FETCH &&
            lat_reg == 4'(isr_pkg::FETCH_CYC - 1)) ||
            (state_reg == isr_pkg::ISR_RECOVER &&
            cnt_reg == CNT_W_TARGET());
         strb_reg.exec <= state_reg == isr_pkg::ISR_WAIT_EXEC &&
            lat_reg == 4'(isr_pkg::EXEC_CYC - 1);
         strb_reg.gpo <= state_reg == isr_pkg::ISR_WAIT_GPO &&
            lat_reg == 4'(isr_pkg::GPO_CYC - 1) && i_gpo_req;
         strb_reg.dma <= dma_done;
      end
   end

   always_comb begin
      o_fetch = strb_reg.fetch;
      o_exec = strb_reg.exec;
      o_gpo_valid = strb_reg.gpo;
      o_dma_access = strb_reg.dma;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pll_enable <= 1'b1;
      end else begin
         o_pll_enable <= !(state_reg == isr_pkg::ISR_STOPPED &&
            !ctrl_reg[isr_pkg::CTRL_PLL_RUN]);
      end
   end

   // apb slave, zero wait states
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= isr_pkg::CTRL_RST;
         mask_reg <= isr_pkg::MASK_RST[isr_pkg::ST_W-1:0];
      end else begin
         if (apb_acc && i_pwrite && i_paddr == isr_pkg::ADDR_CTRL) begin
            ctrl_reg <= i_pwdata;
         end else if (state_reg == isr_pkg::ISR_STOPPED &&
                      ext_prev_reg[0]) begin
            ctrl_reg[isr_pkg::CTRL_STOP] <= 1'b0;
         end
         if (apb_acc && i_pwrite && i_paddr == isr_pkg::ADDR_MASK) begin
            mask_reg <= i_pwdata[isr_pkg::ST_W-1:0];
         end
      end
   end

   assign ev = {o_dma_access, strb_reg.fetch &&
      state_reg == isr_pkg::ISR_IDLE, o_exec, o_fetch};

   // a clearing read drops only the bits it returned, so a set that
   // lands between setup and access is kept
   assign stat_next = (rd_stat ? stat_reg & ~o_prdata[isr_pkg::ST_W-1:0] :
      stat_reg) | ev;

   // set beats the clearing read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stat_reg <= '0;
      end else begin
         stat_reg <= stat_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(stat_next & mask_reg);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_prdata <= '0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable) begin
            o_pslverr <= !(i_paddr == isr_pkg::ADDR_CTRL ||
               i_paddr == isr_pkg::ADDR_STAT ||
               i_paddr == isr_pkg::ADDR_MASK ||
               i_paddr == isr_pkg::ADDR_STATE);
            unique case (i_paddr)
               isr_pkg::ADDR_CTRL: o_prdata <= ctrl_reg;
               isr_pkg::ADDR_STAT: o_prdata <= 32'(stat_reg);
               isr_pkg::ADDR_MASK: o_prdata <= 32'(mask_reg);
               isr_pkg::ADDR_STATE: o_prdata <= 32'(state_reg);
               default: o_prdata <= '0;
            endcase
         end
      end
   end

   // latency and rate checks
   AST_FETCH_LAT: assert property (@(posedge i_clk) disable iff (i_rst)
      state_reg == isr_pkg::ISR_IDLE && ext_take &&
      !ctrl_reg[isr_pkg::CTRL_STOP] |-> ##5 o_fetch)
      else $error("fetch not at latency");
   AST_EXEC_LAT: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fetch && $past(state_reg) == isr_pkg::ISR_WAIT_FETCH
      |-> ##3 o_exec)
      else $error("exec not three after fetch");
   AST_NO_EARLY_EXEC: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fetch |-> ##1 !o_exec [*2])
      else $error("exec too early");
   AST_GPO_LAT: assert property (@(posedge i_clk) disable iff (i_rst)
      o_gpo_valid |-> $past(o_exec))
      else $error("gpo timing wrong");
   AST_DMA_LAT: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(i_dma_ext_trig) && o_dma_take[3] == 1'b0 &&
      $past(o_dma_take[3]) == 1'b0 |-> ##7 o_dma_access)
      else $error("dma access missing");
   AST_DMA_EARLY: assert property (@(posedge i_clk) disable iff (i_rst)
      o_dma_access |-> $past(i_dma_ext_trig, 7))
      else $error("dma access before 4.25 cycles");
   AST_PER_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
      o_periph_take |=> !o_periph_take [*8])
      else $error("peripheral rate too high");
   AST_EDGE_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
      ext_edge_take |=> !ext_edge_take [*7])
      else $error("edge rate too high");
   AST_PLLRUN_WAKE: assert property (@(posedge i_clk) disable iff (i_rst)
      state_reg == isr_pkg::ISR_STOPPED && ext_prev_reg[0] &&
      ctrl_reg[isr_pkg::CTRL_PLL_RUN] |-> ##[8:11] o_fetch)
      else $error("pll-running wake fetch late");
   AST_LOCK_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
      state_reg == isr_pkg::ISR_LOCK |-> !o_fetch)
      else $error("fetch before pll lock");

   COV_INT: cover property (@(posedge i_clk) o_exec);
   COV_WAKE: cover property (@(posedge i_clk)
      state_reg == isr_pkg::ISR_RECOVER ##1 o_fetch);
   COV_DMA: cover property (@(posedge i_clk) o_dma_access);
   COV_GPO: cover property (@(posedge i_clk) o_gpo_valid);
   COV_LOCK: cover property (@(posedge i_clk)
      state_reg == isr_pkg::ISR_LOCK ##1 state_reg == isr_pkg::ISR_RECOVER);
endmodule

//--- isr_top_bench.sv
// self-checking bench: latency, rate gates, stop exit and registers
`timescale 1ns/1ps
module isr_top_bench;
   localparam int STOP_DLY = 20;
   localparam int LOCK = 15;
   localparam int LIMIT = 20000;
   localparam int SPACE[6] = '{isr_pkg::PER_SPACE, isr_pkg::DMAC_SPACE,
      isr_pkg::DRD_SPACE, isr_pkg::DWR_SPACE, isr_pkg::DTMR_SPACE,
      isr_pkg::DEXT_SPACE};
   typedef struct {
      int kind;
      int lo;
      int hi;
      int t0;
      logic [31:0] data;
      logic err;
   } isr_note_type;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [isr_pkg::NUM_EXT-1:0] arm = '0;
   logic level = 1'b0;
   logic [isr_pkg::NUM_EXT-1:0] i_ext_req;
   logic i_pll_locked;
   logic i_periph_req = 1'b0;
   logic i_dmac_req = 1'b0;
   logic i_dma_rd_trig = 1'b0;
   logic i_dma_wr_trig = 1'b0;
   logic i_dma_tmr_trig = 1'b0;
   logic i_dma_ext_trig = 1'b0;
   logic i_gpo_req = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_fetch, o_exec, o_gpo_valid, o_dma_access;
   logic o_periph_take, o_dmac_take, o_pll_enable, o_irq;
   logic [3:0] o_dma_take;
   int cyc = 0;
   int fails = 0;
   int tests_run = 0;
   bit lax = 1'b0;
   isr_note_type notes[$];
   logic [5:0] req_prev = '0;
   int last[6] = '{default: -100};
   int takes[6] = '{default: 0};

   isr_top #(.STOP_DLY(STOP_DLY)) DUT (.i_clk, .i_rst, .i_ext_req,
      .i_periph_req, .i_dmac_req, .i_dma_rd_trig, .i_dma_wr_trig,
      .i_dma_tmr_trig, .i_dma_ext_trig, .i_pll_locked, .i_gpo_req, .i_psel,
      .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .o_fetch, .o_exec, .o_gpo_valid, .o_dma_access,
      .o_periph_take, .o_dmac_take, .o_dma_take, .o_pll_enable, .o_irq);
   isr_partner #(.LOCK_CYC(LOCK)) far_end (.i_clk, .i_rst, .i_arm(arm),
      .i_level(level), .i_fetch(o_fetch), .i_exec(o_exec),
      .i_pll_enable(o_pll_enable), .o_ext_req(i_ext_req),
      .o_pll_locked(i_pll_locked));

   initial begin
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic note(input int kind, input int lo, input int hi,
         input logic [31:0] data, input logic err);
      notes.push_back('{kind, lo, hi, cyc, data, err});
   endtask

   // pulses are matched to the oldest note; strays fail unless lax
   task automatic seen(input int kind, input logic pulse);
      isr_note_type n;
      if (pulse === 1'b1) begin
         if (notes.size() > 0 && notes[0].kind == kind) begin
            n = notes.pop_front();
            tests_run++;
            if (cyc - n.t0 < n.lo || cyc - n.t0 > n.hi) begin
               fails++;
               $display("MISMATCH delay %0d expected %0d..%0d seen %0d",
                  kind, n.lo, n.hi, cyc - n.t0);
            end
         end else if (!lax) begin
            fails++;
            $display("MISMATCH stray event %0d expected 0 seen 1", kind);
         end
      end
   endtask

   always @(posedge i_clk) begin
      logic [5:0] take;
      isr_note_type n;
      take = {o_dma_take, o_dmac_take, o_periph_take};
      cyc <= cyc + 1;
      if (!i_rst) begin
         for (int k = 0; k < 6; k++) begin
            if (take[k] === 1'b1) begin
               tests_run++;
               if (!req_prev[k] || cyc - last[k] < SPACE[k]) begin
                  fails++;
                  $display("MISMATCH take %0d expected gap %0d seen %0d", k,
                     SPACE[k], cyc - last[k]);
               end
               last[k] = cyc;
               takes[k]++;
            end
         end
         seen(1, o_fetch);
         seen(2, o_exec);
         seen(3, o_gpo_valid);
         seen(4, o_dma_access);
         if (i_psel && i_penable && o_pready === 1'b1 &&
               notes.size() > 0) begin
            n = notes.pop_front();
            if (n.kind == 0) begin
               check("read data", n.data, o_prdata);
            end
            check("slave error", 32'(n.err), 32'(o_pslverr));
         end
      end
      req_prev <= {i_dma_ext_trig, i_dma_tmr_trig, i_dma_wr_trig,
         i_dma_rd_trig, i_dmac_req, i_periph_req};
      if (cyc >= LIMIT) begin
         fails++;
         results();
      end
   end

   task automatic apb(input logic wr, input logic [7:0] addr,
         input logic [31:0] wd, input logic [31:0] exp, input logic err);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= addr;
      i_pwdata <= wd;
      note(wr ? 5 : 0, 0, 0, exp, err);
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic drain(input int lim);
      int t;
      t = 0;
      while (notes.size() > 0 && t < lim) begin
         @(posedge i_clk);
         t++;
      end
      if (notes.size() > 0) begin
         fails++;
         $display("MISMATCH pending events expected 0 seen %0d", notes.size());
         notes.delete();
      end
      repeat (4) @(posedge i_clk);
   endtask

   task automatic irq_flow(input int line, input logic lvl);
      @(posedge i_clk);
      level <= lvl;
      arm[line] <= 1'b1;
      note(1, isr_pkg::FETCH_CYC + 1, isr_pkg::FETCH_CYC + 4, 0, 0);
      note(2, isr_pkg::EXEC_CYC + 1, isr_pkg::EXEC_CYC + 4, 0, 0);
      note(3, isr_pkg::GPO_CYC + 1, isr_pkg::GPO_CYC + 4, 0, 0);
      repeat (2) @(posedge i_clk);
      arm <= '0;
      drain(40);
      level <= 1'b0;
   endtask

   // wake from stop on line 0; strays from the wake service are tolerated
   task automatic stop_exit(input logic [31:0] ctrl, input logic pll_on,
         input int lo, input int hi);
      apb(1'b1, isr_pkg::ADDR_CTRL, ctrl, 0, 1'b0);
      repeat (3) @(posedge i_clk);
      check("pll enable", 32'(pll_on), 32'(o_pll_enable));
      lax = 1'b1;
      level <= 1'b1;
      arm[0] <= 1'b1;
      note(1, lo, hi, 0, 0);
      repeat (2) @(posedge i_clk);
      arm <= '0;
      drain(STOP_DLY + LOCK + 200);
      repeat (30) @(posedge i_clk);
      level <= 1'b0;
      lax = 1'b0;
   endtask

   initial begin
      logic [31:0] r;
      r = $urandom(32'hd46f_a61a);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(1'b0, isr_pkg::ADDR_CTRL, 0, isr_pkg::CTRL_RST, 1'b0);
      apb(1'b0, isr_pkg::ADDR_MASK, 0, isr_pkg::MASK_RST, 1'b0);
      apb(1'b0, isr_pkg::ADDR_STAT, 0, 32'h0000_0000, 1'b0);
      apb(1'b0, 8'h10, 0, 32'h0000_0000, 1'b1);
      apb(1'b1, isr_pkg::ADDR_MASK, 32'h0000_000F, 0, 1'b0);
      i_gpo_req <= 1'b1;
      for (int k = 1; k < isr_pkg::NUM_EXT; k++) begin
         irq_flow(k, 1'b0);
      end
      check("irq raised", 32'h0000_0001, 32'(o_irq));
      apb(1'b0, isr_pkg::ADDR_STAT, 0, 32'h0000_0003, 1'b0);
      repeat (2) @(posedge i_clk);
      check("irq cleared", 32'h0000_0000, 32'(o_irq));
      apb(1'b1, isr_pkg::ADDR_CTRL, 32'h0000_0004, 0, 1'b0);
      irq_flow(2, 1'b1);
      apb(1'b1, isr_pkg::ADDR_CTRL, 32'h0000_0000, 0, 1'b0);
      apb(1'b1, isr_pkg::ADDR_MASK, 32'h0000_0000, 0, 1'b0);
      @(posedge i_clk);
      i_dma_ext_trig <= 1'b1;
      note(4, isr_pkg::DMA_CYC + 1, isr_pkg::DMA_CYC + 4, 0, 0);
      @(posedge i_clk);
      i_dma_ext_trig <= 1'b0;
      drain(30);
      check("irq masked", 32'h0000_0000, 32'(o_irq));
      apb(1'b0, isr_pkg::ADDR_STAT, 0, 32'h0000_000B, 1'b0);
      lax = 1'b1;
      repeat (400) begin
         @(posedge i_clk);
         r = $urandom;
         {i_dma_ext_trig, i_dma_tmr_trig, i_dma_wr_trig, i_dma_rd_trig,
            i_dmac_req, i_periph_req} <= r[5:0];
      end
      {i_dma_ext_trig, i_dma_tmr_trig, i_dma_wr_trig, i_dma_rd_trig,
         i_dmac_req, i_periph_req} <= '0;
      repeat (20) @(posedge i_clk);
      lax = 1'b0;
      for (int k = 0; k < 6; k++) begin
         check("gate passes", 32'h0000_0001, 32'(takes[k] > 0));
      end
      stop_exit(32'h0000_0009, 1'b1, isr_pkg::PLLRUN_CYC,
         isr_pkg::PLLRUN_CYC + 2);
      stop_exit(32'h0000_001A, 1'b0, LOCK + 23, LOCK + 30);
      stop_exit(32'h0000_0018, 1'b0, LOCK + STOP_DLY,
         LOCK + STOP_DLY + 30);
      // dma from the random phase, then wake and fetch from the exits
      apb(1'b0, isr_pkg::ADDR_STAT, 0, 32'h0000_000D, 1'b0);
      apb(1'b0, isr_pkg::ADDR_STATE, 0, 32'h0000_0000, 1'b0);
      results();
   end
endmodule
